// [edge_sync.sv]
module edge_sync (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic [2:0] pinIn,
	output logic      [2:0] rise,
	output logic      [2:0] fall
);
	meas_pkg::sync_t st, nx;

	// Two flops per pin, then edge detection on the stable copy only
	always_comb begin
		nx      = st;
		nx.meta = pinIn;
		nx.stab = st.meta;
		nx.prev = st.stab;
		nx.rise = st.stab & ~st.prev;
		nx.fall = ~st.stab & st.prev;
	end

	// State register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign rise = st.rise;
	assign fall = st.fall;
endmodule

// [event_counter_core.sv]
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
module event_counter_core #(
	parameter logic [37:0] WIDTH_MAX_CYC = meas_pkg::WIDTH_MAX_CYC, // Longest pulse width
	parameter logic [37:0] RISE_MAX_CYC  = meas_pkg::RISE_MAX_CYC,  // Longest transition
	parameter logic [37:0] TINT_MAX_CYC  = meas_pkg::TINT_MAX_CYC   // Longest interval
) (
	input  wire logic                core_clk,
	input  wire logic                reset_n,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	input  wire logic [2:0]          trigIn,
	output meas_pkg::frontend_t      frontEnd
);
	meas_pkg::core_t   st;        // Registered state
	meas_pkg::core_t   nx;        // Next state
	meas_pkg::status_t stat;      // Status word as read
	logic [2:0]        rise;      // Synchronised rising edges
	logic [2:0]        fall;      // Synchronised falling edges
	logic [2:0]        slopeEv;   // Edge chosen by each slope bit
	logic [2:0]        chEv;      // Per channel event, channel 3 prescaled
	logic              preIn;     // Prescaler input edge
	logic              ev3;       // Channel 3 after prescaling
	logic [2:0]        fn;        // Current function
	logic              isWidth;   // Pulse width selected
	logic              isRf;      // Rise or fall time selected
	logic              isTime;    // Any interval function
	logic              legal;     // Configuration acceptable
	logic              startEv;   // Gate opening event
	logic              stopEv;    // Gate closing event
	logic              cntEv;     // Event to be counted
	logic [37:0]       minCyc;    // Shortest legal interval
	logic [37:0]       maxCyc;    // Longest legal interval
	logic [37:0]       iv1;       // Interval including this cycle
	logic              addrPhase; // AHB transfer accepted now
	logic              startCmd;  // Start written this cycle
	logic              stopCmd;   // Stop arm written this cycle
	logic              abortCmd;  // Abort written this cycle
	logic              finish;    // Measurement completes now

	// Pin synchroniser and edge detector for the three comparators
	edge_sync u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.pinIn    (trigIn),
		.rise     (rise),
		.fall     (fall)
	);

	// Channel 3 slope is applied before the divider
	assign preIn = st.ctrl.slope[2] ? fall[2] : rise[2];

	event_prescaler u_pre (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.evIn     (preIn),
		.tick     (ev3)
	);

	assign slopeEv = (rise & ~st.ctrl.slope) | (fall & st.ctrl.slope);
	assign chEv    = {ev3, slopeEv[1:0]};

	// Event routing for the selected function
	always_comb begin
		fn      = st.ctrl.func;
		isWidth = (fn == meas_pkg::FN_POS_WIDTH) || (fn == meas_pkg::FN_NEG_WIDTH);
		isRf    = (fn == meas_pkg::FN_RISE) || (fn == meas_pkg::FN_FALL);
		isTime  = isWidth || isRf || (fn == meas_pkg::FN_TINT);
		legal   = 1'b1;
		startEv = 1'b0;
		stopEv  = 1'b0;
		cntEv   = 1'b0;
		minCyc  = '0;
		maxCyc  = '0;
		unique case (fn)
			// Width channel is one bit, so channel 3 cannot be chosen
			meas_pkg::FN_POS_WIDTH, meas_pkg::FN_NEG_WIDTH: begin
				startEv = (fn == meas_pkg::FN_POS_WIDTH) ? rise[st.ctrl.widthCh2]
					: fall[st.ctrl.widthCh2];
				stopEv  = (fn == meas_pkg::FN_POS_WIDTH) ? fall[st.ctrl.widthCh2]
					: rise[st.ctrl.widthCh2];
				minCyc  = meas_pkg::WIDTH_MIN_CYC;
				maxCyc  = WIDTH_MAX_CYC;
			end
			meas_pkg::FN_RATIO: begin
				// Denominator edge opens the gate and counts aperture cycles
				startEv = (st.ctrl.ratioSel == 2'h0) ? rise[1] : rise[0];
				stopEv  = startEv && (st.denCnt + 32'h1 >= st.aper);
				unique case (st.ctrl.ratioSel)
					2'h0:    cntEv = rise[0];
					2'h1:    cntEv = rise[1];
					2'h2:    cntEv = ev3;
					default: legal = 1'b0;
				endcase
			end
			// Path 1 sits at the low level, path 2 at the high one
			meas_pkg::FN_RISE: begin
				startEv = rise[0];
				stopEv  = rise[1];
				minCyc  = meas_pkg::RISE_MIN_CYC;
				maxCyc  = RISE_MAX_CYC;
			end
			meas_pkg::FN_FALL: begin
				startEv = fall[1];
				stopEv  = fall[0];
				minCyc  = meas_pkg::RISE_MIN_CYC;
				maxCyc  = RISE_MAX_CYC;
			end
			meas_pkg::FN_TINT: begin
				startEv = slopeEv[0];
				stopEv  = slopeEv[1];
				minCyc  = meas_pkg::TINT_MIN_CYC;
				maxCyc  = TINT_MAX_CYC;
			end
			meas_pkg::FN_TOTAL: begin
				cntEv = (st.ctrl.totChan == 2'h3) ? 1'b0 : chEv[st.ctrl.totChan];
				legal = (st.ctrl.totChan != 2'h3);
				if (st.ctrl.gateEn) begin
					// The other channel's rising edges bound one gating cycle
					startEv = (st.ctrl.totChan == 2'h0) ? rise[1] : rise[0];
					stopEv  = startEv;
				end else begin
					startEv = 1'b1;
					stopEv  = stopCmd;
				end
			end
			default: legal = 1'b0;
		endcase
	end

	// Bus decode, register writes, measurement sequencer, front end
	always_comb begin
		nx           = st;
		nx.hreadyOut = 1'b1;
		nx.hresp     = 1'b0;
		stat         = '0;
		stat.busy     = (st.fsm != meas_pkg::ST_IDLE);
		stat.done     = st.done;
		stat.rangeErr = st.rangeErr;
		stat.cfgErr   = st.cfgErr;
		stat.gateOpen = (st.fsm == meas_pkg::ST_RUN) || (st.fsm == meas_pkg::ST_HOLD);
		finish   = 1'b0;
		iv1      = st.iv + 38'h1;
		startCmd = st.wrPend && (st.wrAddr == meas_pkg::REG_CMD) && hwdata[meas_pkg::CMD_START_BIT];
		stopCmd  = st.wrPend && (st.wrAddr == meas_pkg::REG_CMD) && hwdata[meas_pkg::CMD_STOP_BIT];
		abortCmd = st.wrPend && (st.wrAddr == meas_pkg::REG_CMD) && hwdata[meas_pkg::CMD_ABORT_BIT];

		// Address phase: capture writes, answer reads with no wait state
		addrPhase = hsel && htrans[1] && hready;
		nx.wrPend = addrPhase && hwrite;
		nx.wrAddr = haddr[7:0];
		if (addrPhase && !hwrite) begin
			// Plain reads have no side effect on the running count
			unique case (haddr[7:0])
				meas_pkg::REG_CTRL:   nx.hrdata = st.ctrl;
				meas_pkg::REG_STATUS: nx.hrdata = stat;
				meas_pkg::REG_APER:   nx.hrdata = st.aper;
				meas_pkg::REG_HOLD:   nx.hrdata = st.holdoff;
				meas_pkg::REG_RES_LO: nx.hrdata = st.result[31:0];
				meas_pkg::REG_RES_HI: nx.hrdata = {16'h0, st.result[47:32]};
				meas_pkg::REG_GATES:  nx.hrdata = {25'h0, st.gates};
				default:              nx.hrdata = 32'h0;
			endcase
		end

		// Data phase of a write; changing settings mid-run is the user's hazard
		if (st.wrPend) begin
			unique case (st.wrAddr)
				meas_pkg::REG_CTRL: nx.ctrl    = meas_pkg::ctrl_t'(hwdata);
				meas_pkg::REG_APER: nx.aper    = hwdata;
				meas_pkg::REG_HOLD: nx.holdoff = hwdata;
				default:            ;
			endcase
		end

		// Measurement sequencer
		unique case (st.fsm)
			meas_pkg::ST_IDLE: ;
			meas_pkg::ST_ARM: begin
				if (startEv) begin
					nx.iv      = '0;
					nx.holdCnt = '0;
					nx.denCnt  = '0;
					// Holdoff only for intervals, and only when nonzero
					if ((fn == meas_pkg::FN_TINT) && st.ctrl.holdEn && (st.holdoff != 32'h0)) begin
						nx.fsm = meas_pkg::ST_HOLD;
					end else begin
						nx.fsm = meas_pkg::ST_RUN;
					end
				end
			end
			meas_pkg::ST_HOLD: begin
				// Stop edges fall through unseen while the holdoff runs
				nx.iv      = iv1;
				nx.holdCnt = st.holdCnt + 32'h1;
				if (st.holdCnt + 32'h1 >= st.holdoff) begin
					nx.fsm = meas_pkg::ST_RUN;
				end
			end
			meas_pkg::ST_RUN: begin
				nx.iv = iv1;
				if (startEv) begin
					nx.denCnt = st.denCnt + 32'h1;
				end
				// Counts saturate rather than wrap
				if (cntEv && !isTime) begin
					nx.result = (st.result >= meas_pkg::TOT_MAX) ? meas_pkg::TOT_MAX
						: st.result + 48'h1;
				end
				if (isTime && (iv1 > maxCyc)) begin
					// A stop that never comes would otherwise hang the core
					nx.rangeErr = 1'b1;
					finish      = 1'b1;
				end else if (stopEv) begin
					nx.gates = st.gates + 7'h1;
					if (isTime) begin
						// Gate spans the transition itself, not the aperture
						nx.result = st.result + {10'h0, iv1};
						if (iv1 < minCyc) begin
							nx.rangeErr = 1'b1;
						end
						if (st.ctrl.avgEn && (st.gates + 7'h1 < meas_pkg::AVG_GATES)) begin
							nx.fsm = meas_pkg::ST_ARM;
						end else begin
							finish = 1'b1;
						end
					end else begin
						finish = 1'b1;
					end
				end
			end
		endcase
		if (finish) begin
			nx.fsm  = meas_pkg::ST_IDLE;
			nx.done = 1'b1;
		end

		// Commands: abort returns to idle, a legal start overrides everything
		if (abortCmd) begin
			nx.fsm = meas_pkg::ST_IDLE;
		end
		if (startCmd) begin
			nx.cfgErr = !legal;
			if (legal) begin
				nx.result   = '0;
				nx.gates    = '0;
				nx.iv       = '0;
				nx.done     = 1'b0;
				nx.rangeErr = 1'b0;
				nx.fsm      = meas_pkg::ST_ARM;
			end
		end

		// Front end settings, one cycle behind the control register
		nx.fe.commonRoute = st.ctrl.common || isRf;
		nx.fe.autoTrig    = (isWidth || isRf) && !st.ctrl.autoDis;
		nx.fe.copyCh1     = isRf;
		if (nx.fe.autoTrig) begin
			nx.fe.lvlA = isRf ? meas_pkg::LVL_LOW : meas_pkg::LVL_HALF;
			nx.fe.lvlB = isRf ? meas_pkg::LVL_HIGH : meas_pkg::LVL_HALF;
		end else begin
			nx.fe.lvlA = st.ctrl.lvlA;
			nx.fe.lvlB = st.ctrl.lvlB;
		end
	end

	// State register; reset takes constants only
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= meas_pkg::CORE_RESET;
		end else begin
			st <= nx;
		end
	end

	// Every output is a field of the state register
	assign hrdata    = st.hrdata;
	assign hreadyout = st.hreadyOut;
	assign hresp     = st.hresp;
	assign frontEnd  = st.fe;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	AST_START_CLEARS: assert property (
		startCmd && legal |=> (st.result == 48'h0) && !st.done && (st.fsm == meas_pkg::ST_ARM))
		else $error("start did not clear the previous result");
	AST_HOLD_IGNORES_STOP: assert property (
		(st.fsm == meas_pkg::ST_HOLD) && (st.holdCnt + 32'h1 < st.holdoff) && !startCmd
		&& !abortCmd |=> (st.fsm == meas_pkg::ST_HOLD) && !st.done)
		else $error("holdoff ended early");
	AST_FIRST_STOP_ENDS: assert property (
		(st.fsm == meas_pkg::ST_RUN) && isTime && stopEv && !startCmd
		|=> (st.fsm != meas_pkg::ST_RUN))
		else $error("stop edge did not end the interval");
	AST_RF_COMMON: assert property (
		isRf |=> frontEnd.commonRoute && frontEnd.copyCh1)
		else $error("rise or fall lost common routing");
	AST_RF_LEVELS: assert property (
		isRf && !st.ctrl.autoDis
		|=> (frontEnd.lvlA == meas_pkg::LVL_LOW) && (frontEnd.lvlB == meas_pkg::LVL_HIGH))
		else $error("rise or fall levels wrong");
	AST_WIDTH_AUTO: assert property (
		isWidth && !st.ctrl.autoDis |=> frontEnd.autoTrig && (frontEnd.lvlA == meas_pkg::LVL_HALF))
		else $error("pulse width level not at half amplitude");
	AST_TOT_SATURATE: assert property (
		(st.fsm == meas_pkg::ST_RUN) && (fn == meas_pkg::FN_TOTAL)
		&& (st.result == meas_pkg::TOT_MAX) && !startCmd |=> (st.result == meas_pkg::TOT_MAX))
		else $error("totalize count wrapped");
	AST_AVG_COUNT: assert property (
		$rose(st.done) && isTime && st.ctrl.avgEn && !st.rangeErr
		|-> (st.gates == meas_pkg::AVG_GATES))
		else $error("average finished with wrong gate count");
	AST_READ_NO_DISTURB: assert property (
		(st.fsm == meas_pkg::ST_RUN) && (fn == meas_pkg::FN_TOTAL) && !st.ctrl.gateEn
		&& !st.wrPend && addrPhase && !hwrite
		|=> (st.fsm == meas_pkg::ST_RUN) && (st.result >= $past(st.result)))
		else $error("read disturbed the running count");

	COV_WIDTH_DONE: cover property ($rose(st.done) && isWidth);
	COV_RATIO_DONE: cover property ($rose(st.done) && (fn == meas_pkg::FN_RATIO));
	COV_GATED_TOT: cover property ($rose(st.done) && (fn == meas_pkg::FN_TOTAL) && st.ctrl.gateEn);
	COV_HOLDOFF: cover property ((st.fsm == meas_pkg::ST_HOLD) ##1 (st.fsm == meas_pkg::ST_RUN));
endmodule

// [event_prescaler.sv]
module event_prescaler (
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic evIn,
	output logic      tick
);
	meas_pkg::presc_t st, nx;

	// One tick per 64 input events; the count wraps by itself
	always_comb begin
		nx      = st;
		nx.tick = evIn && (st.cnt == meas_pkg::PRESCALE_LAST);
		if (evIn) begin
			nx.cnt = st.cnt + 6'h1;
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign tick = st.tick;

	AST_PRESCALE_TICK: assert property (@(posedge core_clk) disable iff (!reset_n)
		evIn && (st.cnt == meas_pkg::PRESCALE_LAST) |=> tick)
		else $error("prescaler missed its 64th event");
	AST_PRESCALE_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
		!(evIn && (st.cnt == meas_pkg::PRESCALE_LAST)) |=> !tick)
		else $error("prescaler ticked early");
endmodule

// [meas_pkg.sv]
package meas_pkg;
	// Core clock period at 200 MHz
	localparam int CLK_PERIOD_NS = 5;
	localparam int NS_PER_MS     = 1_000_000;

	// Measurement limits in their own units
	localparam int     PULSE_MIN_NS = 5;
	localparam int     WIDTH_MAX_MS = 1;
	localparam int     RISE_MIN_NS  = 15;
	localparam int     RISE_MAX_MS  = 1;
	localparam int     TINT_MIN_NS  = 1;
	localparam longint TINT_MAX_S   = 1000;

	// Interval counter width; 1000 s of 5 ns cycles fits in 38 bits
	localparam int IV_W = 38;

	// Cycle counts: least times round up, longest times round down
	localparam logic [IV_W-1:0] WIDTH_MIN_CYC =
		IV_W'((PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [IV_W-1:0] WIDTH_MAX_CYC = IV_W'(WIDTH_MAX_MS * NS_PER_MS / CLK_PERIOD_NS);
	localparam logic [IV_W-1:0] RISE_MIN_CYC =
		IV_W'((RISE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [IV_W-1:0] RISE_MAX_CYC = IV_W'(RISE_MAX_MS * NS_PER_MS / CLK_PERIOD_NS);
	localparam logic [IV_W-1:0] TINT_MIN_CYC =
		IV_W'((TINT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [IV_W-1:0] TINT_MAX_CYC =
		IV_W'(TINT_MAX_S * 64'h0000_0000_3b9a_ca00 / 64'(CLK_PERIOD_NS));

	// Averaging, totalize ceiling (ten to the twelfth minus one), prescaler
	localparam logic [6:0]  AVG_GATES     = 7'h64;
	localparam logic [47:0] TOT_MAX       = 48'h00e8_d4a5_0fff;
	localparam logic [5:0]  PRESCALE_LAST = 6'h3f;

	// Automatic trigger levels in percent of peak amplitude
	localparam logic [6:0] LVL_HALF = 7'h32;
	localparam logic [6:0] LVL_LOW  = 7'h0a;
	localparam logic [6:0] LVL_HIGH = 7'h5a;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_APER   = 8'h0c;
	localparam logic [7:0] REG_HOLD   = 8'h10;
	localparam logic [7:0] REG_RES_LO = 8'h14;
	localparam logic [7:0] REG_RES_HI = 8'h18;
	localparam logic [7:0] REG_GATES  = 8'h1c;

	// Command register bits
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT  = 1;
	localparam int CMD_ABORT_BIT = 2;

	// Measurement function codes
	localparam logic [2:0] FN_POS_WIDTH = 3'h0;
	localparam logic [2:0] FN_NEG_WIDTH = 3'h1;
	localparam logic [2:0] FN_RATIO     = 3'h2;
	localparam logic [2:0] FN_RISE      = 3'h3;
	localparam logic [2:0] FN_FALL      = 3'h4;
	localparam logic [2:0] FN_TINT      = 3'h5;
	localparam logic [2:0] FN_TOTAL     = 3'h6;

	// Control register layout, bit 0 at the bottom
	typedef struct packed {
		logic [1:0] rsvd;
		logic [6:0] lvlB;      // Programmed level, path 2
		logic [6:0] lvlA;      // Programmed level, path 1
		logic       holdEn;    // Stop holdoff enable
		logic       gateEn;    // Gated totalize
		logic       widthCh2;  // Pulse width on channel 2
		logic [1:0] totChan;   // Totalize channel 1..3
		logic [1:0] ratioSel;  // Ratio pairing
		logic [2:0] slope;     // Per channel, 1 = falling
		logic       common;    // Common routing
		logic       autoDis;   // Automatic levels off
		logic       avgEn;     // 100 gate averaging
		logic [2:0] func;
	} ctrl_t;

	// Status register layout
	typedef struct packed {
		logic [26:0] rsvd;
		logic        gateOpen;
		logic        cfgErr;
		logic        rangeErr;
		logic        done;
		logic        busy;
	} status_t;

	// Settings driven to the analog front end
	typedef struct packed {
		logic       commonRoute;
		logic       autoTrig;
		logic [6:0] lvlA;
		logic [6:0] lvlB;
		logic       copyCh1;
	} frontend_t;

	typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_HOLD, ST_RUN} fsm_t;

	// Whole state of the core
	typedef struct packed {
		logic [31:0]     hrdata;
		logic            hreadyOut;
		logic            hresp;
		logic            wrPend;
		logic [7:0]      wrAddr;
		ctrl_t           ctrl;
		logic [31:0]     aper;
		logic [31:0]     holdoff;
		fsm_t            fsm;
		logic [IV_W-1:0] iv;
		logic [31:0]     holdCnt;
		logic [31:0]     denCnt;
		logic [47:0]     result;
		logic [6:0]      gates;
		logic            done;
		logic            rangeErr;
		logic            cfgErr;
		frontend_t       fe;
	} core_t;

	localparam core_t CORE_RESET = '{hreadyOut: 1'b1, aper: 32'h1, fsm: ST_IDLE, default: '0};

	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] stab;
		logic [2:0] prev;
		logic [2:0] rise;
		logic [2:0] fall;
	} sync_t;

	typedef struct packed {
		logic [5:0] cnt;
		logic       tick;
	} presc_t;
endpackage

// [sig_gen.sv]
module sig_gen (
	input  wire logic       core_clk,
	output logic      [2:0] trigIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// Comparator outputs rest low until a burst begins
	initial trigIn = 3'h0;
	// Set one comparator output just after a clock edge
	task automatic setLvl(input int ch, input logic v);
		trigIn[ch] <= v;
	endtask
	// One pulse: hi cycles high, then lo cycles low; hi stays above 5 ns
	task automatic pulse(input int ch, input int hi, input int lo);
		trigIn[ch] <= 1'b1;
		repeat (hi) @(posedge core_clk);
		trigIn[ch] <= 1'b0;
		repeat (lo) @(posedge core_clk);
	endtask
endmodule

// [tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                core_clk    = 1'b0;
	logic                reset_n     = 1'b0;
	logic                hsel        = 1'b0;
	logic                hwrite      = 1'b0;
	logic [31:0]         haddr       = 32'h0;
	logic [31:0]         hwdata      = 32'h0;
	logic [1:0]          htrans      = 2'h0;
	logic [2:0]          hsize       = 3'h2;
	logic [31:0]         hrdata;
	logic                hreadyout;
	logic                hresp;
	logic [2:0]          trigIn;
	meas_pkg::frontend_t frontEnd;
	meas_pkg::ctrl_t     ctrl;
	meas_pkg::frontend_t feExp;
	logic [31:0]         rv;
	int                  badCount    = 0;
	int                  totalChecks = 0;

	// 200 MHz core clock
	always #2.5 core_clk = ~core_clk;

	// Short time limits keep timeout paths reachable in a short run
	event_counter_core #(.WIDTH_MAX_CYC(38'hc8), .RISE_MAX_CYC(38'hc8),
		.TINT_MAX_CYC(38'h3e8)) event_counter_core_inst (
		.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .trigIn(trigIn), .frontEnd(frontEnd));
	sig_gen sig_gen_inst (.core_clk(core_clk), .trigIn(trigIn));

	// Compare and count; four-state so an unknown never matches
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		totalChecks++;
		if (got !== exp) begin
			badCount++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic endOfTest();
		$display("checks %0d, mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Wait for hready under a bound; a stuck bus ends the run
	task automatic waitRdy();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			badCount++;
			endOfTest();
		end
	endtask
	// Single word write: address phase, then data phase
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= 1'b1;
		htrans <= 2'h2;
		waitRdy();
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
	endtask
	// Single word read: data taken at the edge ending the data phase
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= 1'b0;
		htrans <= 2'h2;
		waitRdy();
		htrans <= 2'h0;
		waitRdy();
		d = hrdata;
	endtask
	// Reset values, unmapped place, default automatic half level
	task automatic testReset();
		rd(meas_pkg::REG_CTRL, rv);
		chk("ctrl", 48'h0, 48'(rv));
		rd(meas_pkg::REG_APER, rv);
		chk("aper", 48'h1, 48'(rv));
		rd(8'h20, rv);
		chk("unmapped", 48'h0, 48'(rv));
		chk("hresp", 48'h0, 48'(hresp));
		feExp = '{1'b0, 1'b1, meas_pkg::LVL_HALF, meas_pkg::LVL_HALF, 1'b0};
		chk("frontEnd", 48'(feExp), 48'(frontEnd));
		$display("reset test done");
	endtask
	// Positive width of 20 cycles on channel 1
	task automatic testWidth();
		ctrl = '0;
		wr(meas_pkg::REG_CTRL, 32'(ctrl));
		wr(meas_pkg::REG_CMD, 32'h1);
		sig_gen_inst.pulse(0, 20, 10);
		rd(meas_pkg::REG_RES_LO, rv);
		chk("width", 48'd20, 48'(rv));
		rd(meas_pkg::REG_STATUS, rv);
		chk("done", 48'h1, 48'(rv[1]));
		$display("width test done");
	endtask
	// Rise time forces common routing, 10/90 levels, copy of channel 1
	task automatic testRise();
		ctrl = '0;
		ctrl.func = meas_pkg::FN_RISE;
		wr(meas_pkg::REG_CTRL, 32'(ctrl));
		repeat (2) @(posedge core_clk);
		feExp = '{1'b1, 1'b1, meas_pkg::LVL_LOW, meas_pkg::LVL_HIGH, 1'b1};
		chk("riseFe", 48'(feExp), 48'(frontEnd));
		ctrl.autoDis = 1'b1;
		ctrl.lvlA = 7'h20;
		ctrl.lvlB = 7'h40;
		wr(meas_pkg::REG_CTRL, 32'(ctrl));
		repeat (2) @(posedge core_clk);
		chk("common", 48'h1, 48'(frontEnd.commonRoute));
		chk("levels", 48'h1040, 48'({frontEnd.lvlA, frontEnd.lvlB}));
		$display("rise test done");
	endtask
	// Interval with holdoff 10: stop at +3 ignored, stop at +20 ends it
	task automatic testHold();
		ctrl = '0;
		ctrl.func = meas_pkg::FN_TINT;
		ctrl.holdEn = 1'b1;
		wr(meas_pkg::REG_CTRL, 32'(ctrl));
		wr(meas_pkg::REG_HOLD, 32'ha);
		wr(meas_pkg::REG_CMD, 32'h1);
		sig_gen_inst.setLvl(0, 1'b1);
		repeat (3) @(posedge core_clk);
		sig_gen_inst.pulse(1, 2, 15);
		sig_gen_inst.pulse(1, 4, 10);
		sig_gen_inst.setLvl(0, 1'b0);
		rd(meas_pkg::REG_RES_LO, rv);
		chk("interval", 48'd20, 48'(rv));
		$display("holdoff test done");
	endtask
	// Ungated totalize: live read, stop arm, restart clears count
	task automatic testTotal();
		ctrl = '0;
		ctrl.func = meas_pkg::FN_TOTAL;
		wr(meas_pkg::REG_CTRL, 32'(ctrl));
		wr(meas_pkg::REG_CMD, 32'h1);
		for (int i = 0; i < 5; i++) sig_gen_inst.pulse(0, 2, 2);
		repeat (6) @(posedge core_clk);
		rd(meas_pkg::REG_RES_LO, rv);
		chk("subtotal", 48'd5, 48'(rv));
		for (int i = 0; i < 3; i++) sig_gen_inst.pulse(0, 2, 2);
		repeat (6) @(posedge core_clk);
		wr(meas_pkg::REG_CMD, 32'h2);
		rd(meas_pkg::REG_RES_LO, rv);
		chk("total", 48'd8, 48'(rv));
		wr(meas_pkg::REG_CMD, 32'h1);
		wr(meas_pkg::REG_CMD, 32'h2);
		rd(meas_pkg::REG_RES_LO, rv);
		chk("empty", 48'h0, 48'(rv));
		$display("totalize test done");
	endtask
	// Ratio: illegal pairing refused, then ch1 edges over two ch2 cycles
	task automatic testRatio();
		ctrl = '0;
		ctrl.func = meas_pkg::FN_RATIO;
		ctrl.ratioSel = 2'h3;
		wr(meas_pkg::REG_CTRL, 32'(ctrl));
		wr(meas_pkg::REG_CMD, 32'h1);
		rd(meas_pkg::REG_STATUS, rv);
		chk("cfgErr", 48'h1, 48'(rv[3]));
		ctrl.ratioSel = 2'h0;
		wr(meas_pkg::REG_CTRL, 32'(ctrl));
		wr(meas_pkg::REG_APER, 32'h2);
		wr(meas_pkg::REG_CMD, 32'h1);
		// Faster signal on the numerator: two of its edges per ch2 cycle
		for (int i = 0; i < 3; i++) begin
			sig_gen_inst.pulse(1, 2, 2);
			if (i < 2) begin
				sig_gen_inst.pulse(0, 2, 2);
				sig_gen_inst.pulse(0, 2, 2);
			end
		end
		repeat (4) @(posedge core_clk);
		rd(meas_pkg::REG_RES_LO, rv);
		chk("ratio", 48'h4, 48'(rv));
		rd(meas_pkg::REG_STATUS, rv);
		chk("ratioStat", 48'h2, 48'(rv[3:0]));
		$display("ratio test done");
	endtask
	// Gated totalize: ch2 edges counted inside one ch1 cycle
	task automatic testGated();
		ctrl = '0;
		ctrl.func = meas_pkg::FN_TOTAL;
		ctrl.totChan = 2'h1;
		ctrl.gateEn = 1'b1;
		wr(meas_pkg::REG_CTRL, 32'(ctrl));
		wr(meas_pkg::REG_CMD, 32'h1);
		sig_gen_inst.pulse(0, 2, 2);
		for (int i = 0; i < 3; i++) sig_gen_inst.pulse(1, 2, 2);
		sig_gen_inst.pulse(0, 2, 6);
		rd(meas_pkg::REG_RES_LO, rv);
		chk("gated", 48'h3, 48'(rv));
		rd(meas_pkg::REG_GATES, rv);
		chk("gates", 48'h1, 48'(rv));
		$display("gated totalize test done");
	endtask

	// Main sequence: reset held 5 cycles, then each scenario
	initial begin
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		testReset();
		testWidth();
		testRise();
		testHold();
		testTotal();
		testRatio();
		testGated();
		endOfTest();
	end
endmodule
